// ==== hw/mtcp_defines.svh ====
/*
 * Constants for the MAC transmit control and PAUSE block: register offsets,
 * field positions, reset values, frame constants and nibble counts.
 * Assumes inclusion by bare name from the design; definitions only.
 */
`ifndef MTCP_DEFINES_SVH
`define MTCP_DEFINES_SVH

// register byte offsets on the bus
`define MTCP_OFS_MAC_CTRL    8'h00
`define MTCP_OFS_TX_CTRL     8'h04
`define MTCP_OFS_EVENT       8'h08
`define MTCP_OFS_SA_LOW      8'h0C
`define MTCP_OFS_SA_HIGH     8'h10
`define MTCP_OFS_PAUSE_OPD   8'h14

// field positions
`define MTCP_MAC_EN_BIT      0
`define MTCP_FCE_BIT         1
`define MTCP_GTS_BIT         0
`define MTCP_HBC_BIT         1
`define MTCP_FDX_BIT         2
`define MTCP_TFC_BIT         3
`define MTCP_EV_GSD_BIT      0
`define MTCP_EV_HB_BIT       1

// reset values
`define MTCP_TCR_RESET       4'h0
`define MTCP_MAC_CTRL_RESET  2'h0

// pause frame content
`define MTCP_PAUSE_TYPE      16'h8808
`define MTCP_PAUSE_OPCODE    16'h0001
`define MTCP_PAUSE_DA        48'h0180C2000001
`define MTCP_CRC_POLY        32'hEDB88320
`define MTCP_CRC_INIT        32'hFFFFFFFF

// nibble values and counts on the link, and frame byte counts
`define MTCP_PRE_NIB         4'h5
`define MTCP_SFD_NIB         4'hD
`define MTCP_PRE_LAST        5'h0F
`define MTCP_IFG_LAST        5'h17
`define MTCP_QUANTUM_LAST    7'h7F
`define MTCP_CTRL_BODY       7'h3C
`define MTCP_CTRL_LAST       7'h3F
`define MTCP_EARLY_LIMIT     7'h40

`endif

// ==== hw/mtcp_pkg.sv ====
/*
 * Types for the MAC transmit control and PAUSE block.
 * Assumes the defines header is compiled alongside; no imports are used.
 */
package mtcp_pkg;

	typedef enum logic [4:0] {
		MTCP_S_IDLE = 5'h01,
		MTCP_S_PRE  = 5'h02,
		MTCP_S_DATA = 5'h04,
		MTCP_S_CTRL = 5'h08,
		MTCP_S_GAP  = 5'h10
	} mtcp_tx_state_t;

	typedef struct packed {
		logic       tx_en;
		logic       tx_er;
		logic [3:0] txd;
	} mtcp_mii_tx_t;

endpackage

// ==== hw/mtcp_tx_ctrl.sv ====
/*
 * MAC transmit control: graceful stop, full duplex, heartbeat check,
 * PAUSE frame generation and honouring, station address registers.
 * Assumes a classic Wishbone master on the system clock, an MII PHY whose
 * transmit clock is much slower than the system clock, a byte stream from
 * the transmit FIFO on the system clock, and pause events from the receiver.
 */
// Chosen here: the Wishbone register port and the address map.
`include "mtcp_defines.svh"

// Functional notes
// - reset clears whole transmit control register
// - received pause bit tracks active pause
// - send-pause request halts data, raises done
// - send one PAUSE frame, clear request, resume
// - PAUSE frame allowed while stopped or paused
// - full duplex ignores carrier and collision
// - heartbeat check flags missing collision after frame
// - graceful stop finishes frame, then done event
// - idle graceful stop gives done at once
// - clearing graceful stop resumes next frame
// - early collision under stop retransmits later
// - low address bytes 0..3 for matching
// - pause source address from station registers
// - high register bytes 4,5 for matching
// - high register type field fixed 0x8808
// - opcode field fixed 0x0001
// - pause length sent as duration field
// - received pause halts data for duration
module mtcp_tx_ctrl (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_wb_cyc,
	input  wire logic                 i_wb_stb,
	input  wire logic                 i_wb_we,
	input  wire logic [7:0]           i_wb_adr,
	input  wire logic [3:0]           i_wb_sel,
	input  wire logic [31:0]          i_wb_dat,
	output logic                      o_wb_ack,
	output logic      [31:0]          o_wb_dat,
	input  wire logic                 i_mii_tx_clk,
	input  wire logic                 i_mii_crs,
	input  wire logic                 i_mii_col,
	output mtcp_pkg::mtcp_mii_tx_t    o_mii_tx,
	input  wire logic                 i_frm_valid,
	input  wire logic [7:0]           i_frm_data,
	input  wire logic                 i_frm_last,
	output logic                      o_frm_ready,
	output logic                      o_frm_rewind,
	input  wire logic                 i_rx_pause_valid,
	input  wire logic [15:0]          i_rx_pause_quanta,
	output logic      [47:0]          o_station_addr
);

	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MTCP_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// header bytes first, then zero pad up to the fcs
	function automatic logic [7:0] ctrl_byte(input logic [6:0] idx, input logic [47:0] sa,
		input logic [15:0] len);
		logic [143:0] hdr;
		int unsigned  sh;
		hdr = {`MTCP_PAUSE_DA, sa, `MTCP_PAUSE_TYPE, `MTCP_PAUSE_OPCODE, len};
		sh  = 0;
		if (idx < 7'h12) begin
			sh = 8 * (17 - int'(idx));
			return 8'(hdr >> sh);
		end
		return 8'h00;
	endfunction

	logic [2:0]                  sync_a;
	logic [2:0]                  sync_b;
	logic                        clk_prev;
	logic                        tick;
	logic                        crs_s;
	logic                        col_s;
	logic                        mac_enable;
	logic                        rx_fc_enable;
	logic [3:0]                  tcr_ctl;
	logic                        rx_paused;
	logic                        ev_gsd;
	logic                        ev_hb;
	logic [31:0]                 sa_low;
	logic [15:0]                 sa_upper;
	logic [15:0]                 pause_len;
	logic [15:0]                 pause_cnt;
	logic [6:0]                  quant_div;
	logic                        wb_req;
	logic                        wb_wr;
	logic [31:0]                 tcr_merged;
	logic [31:0]                 mac_merged;
	logic [31:0]                 sal_merged;
	logic [31:0]                 sah_merged;
	logic [31:0]                 opd_merged;
	mtcp_pkg::mtcp_tx_state_t    state;
	logic [4:0]                  nib_cnt;
	logic                        nib_hi;
	logic [6:0]                  byte_idx;
	logic [7:0]                  cur_byte;
	logic                        cur_last;
	logic                        cur_err;
	logic                        is_ctrl;
	logic [31:0]                 crc;
	logic                        hb_armed;
	logic                        hb_seen;
	logic                        hb_fail;
	logic                        tfc_done;
	logic                        halt_seen;
	logic                        gsd_set;
	logic [47:0]                 sa48;
	logic [7:0]                  ctrl_now;
	logic [7:0]                  src_byte;
	logic                        fdx;
	logic                        graceful_stop;
	logic                        tfc;
	logic                        early_col;
	logic                        carrier_ok;
	logic                        data_active;

	// link clock and carrier inputs cross in through two flops
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_a   <= 3'h0;
			sync_b   <= 3'h0;
			clk_prev <= 1'b0;
		end else begin
			sync_a   <= {i_mii_col, i_mii_crs, i_mii_tx_clk};
			sync_b   <= sync_a;
			clk_prev <= sync_b[0];
		end
	end

	assign tick  = sync_b[0] & ~clk_prev;
	assign crs_s = sync_b[1];
	assign col_s = sync_b[2];

	assign graceful_stop         = tcr_ctl[`MTCP_GTS_BIT];
	assign fdx         = tcr_ctl[`MTCP_FDX_BIT];
	assign tfc         = tcr_ctl[`MTCP_TFC_BIT];
	assign sa48        = {sa_low, sa_upper};
	assign carrier_ok  = fdx | ~crs_s;
	assign early_col   = ~fdx & col_s & (byte_idx < `MTCP_EARLY_LIMIT);
	assign data_active = (state == mtcp_pkg::MTCP_S_PRE || state == mtcp_pkg::MTCP_S_DATA)
		& ~is_ctrl;
	assign gsd_set     = (graceful_stop | tfc) & ~halt_seen & ~data_active;

	// fcs goes out complemented, low byte first
	always_comb begin
		if (byte_idx < `MTCP_CTRL_BODY) begin
			ctrl_now = ctrl_byte(byte_idx, sa48, pause_len);
		end else begin
			ctrl_now = 8'(~crc >> (8 * int'(byte_idx - `MTCP_CTRL_BODY)));
		end
		src_byte = is_ctrl ? ctrl_now : cur_byte;
	end

	assign wb_req     = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wb_wr      = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
	assign tcr_merged = byte_merge({28'h0000000, tcr_ctl}, i_wb_dat, i_wb_sel);
	assign mac_merged = byte_merge({30'h00000000, rx_fc_enable, mac_enable}, i_wb_dat, i_wb_sel);
	assign sal_merged = byte_merge(sa_low, i_wb_dat, i_wb_sel);
	assign sah_merged = byte_merge({sa_upper, `MTCP_PAUSE_TYPE}, i_wb_dat, i_wb_sel);
	assign opd_merged = byte_merge({`MTCP_PAUSE_OPCODE, pause_len}, i_wb_dat, i_wb_sel);

	// one wait state: ack follows the request, drops after one cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= wb_req;
			if (wb_req) begin
				case (i_wb_adr)
					`MTCP_OFS_MAC_CTRL:  o_wb_dat <= {30'h00000000, rx_fc_enable, mac_enable};
					`MTCP_OFS_TX_CTRL:   o_wb_dat <= {27'h0000000, rx_paused, tcr_ctl};
					`MTCP_OFS_EVENT:     o_wb_dat <= {30'h00000000, ev_hb, ev_gsd};
					`MTCP_OFS_SA_LOW:    o_wb_dat <= sa_low;
					`MTCP_OFS_SA_HIGH:   o_wb_dat <= {sa_upper, `MTCP_PAUSE_TYPE};
					`MTCP_OFS_PAUSE_OPD: o_wb_dat <= {`MTCP_PAUSE_OPCODE, pause_len};
					default:             o_wb_dat <= 32'h00000000;
				endcase
			end
		end
	end

	// a software write wins over the hardware clear of the pause request
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tcr_ctl <= `MTCP_TCR_RESET;
		end else if (wb_wr && i_wb_adr == `MTCP_OFS_TX_CTRL) begin
			tcr_ctl <= tcr_merged[3:0];
		end else if (tfc_done) begin
			tcr_ctl[`MTCP_TFC_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{rx_fc_enable, mac_enable} <= `MTCP_MAC_CTRL_RESET;
		end else if (wb_wr && i_wb_adr == `MTCP_OFS_MAC_CTRL) begin
			{rx_fc_enable, mac_enable} <= mac_merged[1:0];
		end
	end

	// write-one-to-clear; a new event in the same cycle stays set
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ev_gsd    <= 1'b0;
			ev_hb     <= 1'b0;
			halt_seen <= 1'b0;
		end else begin
			ev_gsd    <= (ev_gsd & ~(wb_wr && i_wb_adr == `MTCP_OFS_EVENT
				&& i_wb_sel[0] && i_wb_dat[`MTCP_EV_GSD_BIT])) | gsd_set;
			ev_hb     <= (ev_hb & ~(wb_wr && i_wb_adr == `MTCP_OFS_EVENT
				&& i_wb_sel[0] && i_wb_dat[`MTCP_EV_HB_BIT])) | hb_fail;
			halt_seen <= (graceful_stop | tfc) & (halt_seen | gsd_set);
		end
	end

	// left unreset on purpose: software must load these before use
	always_ff @(posedge i_sys_clk) begin
		if (wb_wr && i_wb_adr == `MTCP_OFS_SA_LOW) begin
			sa_low <= sal_merged;
		end
		if (wb_wr && i_wb_adr == `MTCP_OFS_SA_HIGH) begin
			sa_upper <= sah_merged[31:16];
		end
		if (wb_wr && i_wb_adr == `MTCP_OFS_PAUSE_OPD) begin
			pause_len <= opd_merged[15:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_station_addr <= 48'h000000000000;
		end else begin
			o_station_addr <= {sa_low[31:24], sa_low[23:16], sa_low[15:8], sa_low[7:0],
				sa_upper[15:8], sa_upper[7:0]};
		end
	end

	// one quantum is 512 bit times, 128 nibble clocks
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pause_cnt <= 16'h0000;
			quant_div <= 7'h00;
			rx_paused <= 1'b0;
		end else if (i_rx_pause_valid && rx_fc_enable) begin
			pause_cnt <= i_rx_pause_quanta;
			quant_div <= 7'h00;
			rx_paused <= (i_rx_pause_quanta != 16'h0000);
		end else if (rx_paused && tick) begin
			if (quant_div == `MTCP_QUANTUM_LAST) begin
				quant_div <= 7'h00;
				pause_cnt <= pause_cnt - 16'h0001;
				if (pause_cnt == 16'h0001) begin
					rx_paused <= 1'b0;
				end
			end else begin
				quant_div <= quant_div + 7'h01;
			end
		end
	end

	// fifo byte arrives in the cycle ready is high
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur_byte <= 8'h00;
			cur_last <= 1'b0;
			cur_err  <= 1'b0;
		end else if (o_frm_ready) begin
			cur_byte <= i_frm_data;
			cur_last <= i_frm_last | ~i_frm_valid;
			cur_err  <= ~i_frm_valid;
		end
	end

	// transmit sequencer, one step per link clock edge
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state        <= mtcp_pkg::MTCP_S_IDLE;
			o_mii_tx     <= '0;
			o_frm_ready  <= 1'b0;
			o_frm_rewind <= 1'b0;
			nib_cnt      <= 5'h00;
			nib_hi       <= 1'b0;
			byte_idx     <= 7'h00;
			is_ctrl      <= 1'b0;
			crc          <= `MTCP_CRC_INIT;
			hb_armed     <= 1'b0;
			hb_seen      <= 1'b0;
			hb_fail      <= 1'b0;
			tfc_done     <= 1'b0;
		end else begin
			o_frm_ready  <= 1'b0;
			o_frm_rewind <= 1'b0;
			hb_fail      <= 1'b0;
			tfc_done     <= 1'b0;
			if (tick) begin
				case (state)
					mtcp_pkg::MTCP_S_IDLE: begin
						o_mii_tx <= '0;
						byte_idx <= 7'h00;
						nib_cnt  <= 5'h01;
						if (mac_enable && tfc && carrier_ok) begin
							is_ctrl  <= 1'b1;
							state    <= mtcp_pkg::MTCP_S_PRE;
							o_mii_tx <= '{tx_en: 1'b1, tx_er: 1'b0, txd: `MTCP_PRE_NIB};
						end else if (mac_enable && !graceful_stop && !tfc && !rx_paused && i_frm_valid
							&& carrier_ok) begin
							is_ctrl  <= 1'b0;
							state    <= mtcp_pkg::MTCP_S_PRE;
							o_mii_tx <= '{tx_en: 1'b1, tx_er: 1'b0, txd: `MTCP_PRE_NIB};
						end
					end
					mtcp_pkg::MTCP_S_PRE: begin
						if (early_col) begin
							o_mii_tx     <= '0;
							o_frm_rewind <= ~is_ctrl;
							hb_armed     <= 1'b0;
							nib_cnt      <= 5'h00;
							state        <= mtcp_pkg::MTCP_S_GAP;
						end else if (nib_cnt == `MTCP_PRE_LAST) begin
							o_mii_tx.txd <= `MTCP_SFD_NIB;
							nib_hi       <= 1'b0;
							crc          <= `MTCP_CRC_INIT;
							o_frm_ready  <= ~is_ctrl;
							state        <= is_ctrl ? mtcp_pkg::MTCP_S_CTRL : mtcp_pkg::MTCP_S_DATA;
						end else begin
							o_mii_tx.txd <= `MTCP_PRE_NIB;
							nib_cnt      <= nib_cnt + 5'h01;
						end
					end
					mtcp_pkg::MTCP_S_DATA,
					mtcp_pkg::MTCP_S_CTRL: begin
						nib_cnt <= 5'h00;
						if (early_col) begin
							// no jam; the frame is replayed from its start
							o_mii_tx     <= '0;
							o_frm_rewind <= ~is_ctrl;
							hb_armed     <= 1'b0;
							state        <= mtcp_pkg::MTCP_S_GAP;
						end else if (!is_ctrl && cur_err) begin
							o_mii_tx <= '{tx_en: 1'b1, tx_er: 1'b1, txd: 4'h0};
							hb_armed <= 1'b0;
							state    <= mtcp_pkg::MTCP_S_GAP;
						end else if (!nib_hi) begin
							o_mii_tx.txd <= src_byte[3:0];
							nib_hi       <= 1'b1;
						end else begin
							o_mii_tx.txd <= src_byte[7:4];
							nib_hi       <= 1'b0;
							byte_idx     <= (byte_idx == `MTCP_EARLY_LIMIT) ? byte_idx
								: byte_idx + 7'h01;
							if (is_ctrl && byte_idx < `MTCP_CTRL_BODY) begin
								crc <= crc32_byte(crc, src_byte);
							end
							if (is_ctrl ? (byte_idx == `MTCP_CTRL_LAST) : cur_last) begin
								tfc_done <= is_ctrl;
								hb_armed <= tcr_ctl[`MTCP_HBC_BIT] & ~fdx;
								state    <= mtcp_pkg::MTCP_S_GAP;
							end else begin
								o_frm_ready <= ~is_ctrl;
							end
						end
					end
					mtcp_pkg::MTCP_S_GAP: begin
						// the interframe gap doubles as the heartbeat window
						o_mii_tx <= '0;
						hb_seen  <= (hb_seen | col_s) & (nib_cnt != 5'h00 | col_s);
						if (nib_cnt == `MTCP_IFG_LAST) begin
							hb_fail  <= hb_armed & ~hb_seen & ~col_s;
							hb_armed <= 1'b0;
							hb_seen  <= 1'b0;
							state    <= mtcp_pkg::MTCP_S_IDLE;
						end else begin
							nib_cnt <= nib_cnt + 5'h01;
						end
					end
					default: begin
						o_mii_tx <= '0;
						state    <= mtcp_pkg::MTCP_S_IDLE;
					end
				endcase
			end
		end
	end

endmodule // mtcp_tx_ctrl

// ==== test/mtcp_phy_model.sv ====
/* PHY model: free transmit clock, carrier echo, nibble capture.
   Assumes the package is compiled first. */
module mtcp_phy_model (
	output logic                       o_tx_clk,
	output logic                       o_crs,
	output logic                       o_col,
	input  wire logic                  i_col_req,
	input  wire mtcp_pkg::mtcp_mii_tx_t i_mii_tx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx_byte [0:63];
	logic [3:0] low_nib;
	int         n_nib = 0;
	int         n_frames = 0;
	initial begin
		o_tx_clk = 1'b0;
		forever #200 o_tx_clk = ~o_tx_clk;
	end
	// carrier follows our own transmit, as a half duplex phy would show
	assign o_crs = i_mii_tx.tx_en;
	assign o_col = i_col_req;
	always @(posedge o_tx_clk) begin
		if (i_mii_tx.tx_en) begin
			if (n_nib >= 16 && n_nib[0] == 1'b0)
				low_nib <= i_mii_tx.txd;
			if (n_nib >= 17 && n_nib[0] == 1'b1 && n_nib < 144)
				rx_byte[(n_nib - 17) / 2] <= {i_mii_tx.txd, low_nib};
			n_nib <= n_nib + 1;
		end else if (n_nib != 0) begin
			n_frames <= n_frames + 1;
			n_nib <= 0;
		end
	end
endmodule // mtcp_phy_model

// ==== test/mtcp_tx_ctrl_monitor.sv ====
/* Checker for the transmit control block, bound onto its top ports.
   Assumes the defines header and the package are compiled first. */
`include "mtcp_defines.svh"
module mtcp_tx_ctrl_monitor (
	input wire logic                   i_sys_clk,
	input wire logic                   i_rst_n,
	input wire logic                   i_wb_cyc,
	input wire logic                   i_wb_stb,
	input wire logic                   i_wb_we,
	input wire logic [7:0]             i_wb_adr,
	input wire logic [3:0]             i_wb_sel,
	input wire logic [31:0]            i_wb_dat,
	input wire logic                   o_wb_ack,
	input wire logic [31:0]            o_wb_dat,
	input wire mtcp_pkg::mtcp_mii_tx_t o_mii_tx,
	input wire logic [47:0]            o_station_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic        rd_go;
	logic        wr_go;
	logic [15:0] dat_hi;
	assign rd_go = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
	assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
	assign dat_hi = i_wb_dat[31:16];

	ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	ack_reply_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered in one cycle");
	type_const_a: assert property (
		rd_go && i_wb_adr == `MTCP_OFS_SA_HIGH |=> o_wb_dat[15:0] == `MTCP_PAUSE_TYPE)
		else $error("type field not constant");
	opcode_const_a: assert property (
		rd_go && i_wb_adr == `MTCP_OFS_PAUSE_OPD |=> o_wb_dat[31:16] == `MTCP_PAUSE_OPCODE)
		else $error("opcode field not constant");
	tcr_spare_a: assert property (
		rd_go && i_wb_adr == `MTCP_OFS_TX_CTRL |=> o_wb_dat[31:5] == 27'h0)
		else $error("spare control bits not zero");
	sta_low_a: assert property (
		wr_go && i_wb_adr == `MTCP_OFS_SA_LOW && i_wb_sel == 4'hF
		|=> ##1 o_station_addr[47:16] == $past(i_wb_dat, 2))
		else $error("address bytes 0 to 3 misplaced");
	sta_high_a: assert property (
		wr_go && i_wb_adr == `MTCP_OFS_SA_HIGH && i_wb_sel[3:2] == 2'b11
		|=> ##1 o_station_addr[15:0] == $past(dat_hi, 2))
		else $error("address bytes 4 and 5 misplaced");
	pre_start_a: assert property (
		$rose(o_mii_tx.tx_en) |-> o_mii_tx.txd == `MTCP_PRE_NIB)
		else $error("frame not opened by preamble");
	pre_hold_a: assert property (
		$rose(o_mii_tx.tx_en) |-> o_mii_tx.tx_en [*8])
		else $error("transmit enable dropped in preamble");
	rst_idle_a: assert property (disable iff (1'b0)
		!i_rst_n |-> o_mii_tx == 6'h00 && !o_wb_ack)
		else $error("outputs active in reset");
endmodule // mtcp_tx_ctrl_monitor

// ==== test/tb.sv ====
/* Self-checking bench for the transmit control block.
   Assumes design, package, defines, monitor and phy model are compiled. */
`include "mtcp_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   clk, rst_n, cyc, stb, we, col_req;
	logic                   ack, tx_clk, crs, col, f_valid, f_last, f_ready, rxp, rew, rew_seen;
	logic [7:0]             adr, idx;
	logic [3:0]             sel;
	logic [15:0]            quanta;
	logic [31:0]            dat_w, dat_r, q;
	logic [47:0]            sta;
	mtcp_pkg::mtcp_mii_tx_t mii;
	int                     failures, n_checks, f0;

	mtcp_tx_ctrl dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat_w), .o_wb_ack(ack),
		.o_wb_dat(dat_r), .i_mii_tx_clk(tx_clk), .i_mii_crs(crs), .i_mii_col(col),
		.o_mii_tx(mii), .i_frm_valid(f_valid), .i_frm_data(idx), .i_frm_last(f_last),
		.o_frm_ready(f_ready), .o_frm_rewind(rew), .i_rx_pause_valid(rxp),
		.i_rx_pause_quanta(quanta), .o_station_addr(sta));
	mtcp_phy_model phy (.o_tx_clk(tx_clk), .o_crs(crs), .o_col(col), .i_col_req(col_req),
		.i_mii_tx(mii));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// byte source: one 64-byte frame holding 0..63
	assign f_last = (idx == 8'h3F);
	always @(posedge clk) begin
		if (rew) begin
			idx <= 8'h00;
			f_valid <= 1'b1;
			rew_seen <= 1'b1;
		end else if (f_ready) begin
			idx <= idx + 8'h01;
			if (f_last)
				f_valid <= 1'b0;
		end
	end

	task automatic test_done();
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang();
		failures++;
		test_done();
	endtask
	task automatic chk(input logic [47:0] e, input logic [47:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// standard ethernet crc over the captured bytes, sent complemented
	function automatic logic [31:0] fcs_of(input int n);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int k = 0; k < n; k++)
			for (int b = 0; b < 8; b++)
				c = (c[0] ^ phy.rx_byte[k][b]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
		return ~c;
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 40);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (i >= 40)
			hang();
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int i;
		for (i = 0; i < 900; i++) begin
			wb(1'b0, a, 32'h0);
			if (q[b] === v)
				break;
		end
		if (i == 900)
			hang();
	endtask
	task automatic wait_frames(input int n);
		int i;
		for (i = 0; i < 4000 && phy.n_frames != n; i++)
			@(posedge clk);
		if (i == 4000)
			hang();
		repeat (20) @(posedge clk);
	endtask
	task automatic go();
		idx <= 8'h00;
		f_valid <= 1'b1;
	endtask

	task automatic t_reset();
		wb(1'b0, `MTCP_OFS_TX_CTRL, 32'h0);
		chk(32'h0, q);
		wb(1'b0, 8'h3C, 32'h0);
		chk(32'h0, q);
	endtask
	task automatic t_addr();
		wb(1'b1, `MTCP_OFS_SA_LOW, 32'h02A1B2C3);
		wb(1'b1, `MTCP_OFS_SA_HIGH, 32'hD4E5FFFF);
		wb(1'b1, `MTCP_OFS_PAUSE_OPD, 32'hFFFF1234);
		wb(1'b0, `MTCP_OFS_SA_HIGH, 32'h0);
		chk(32'hD4E58808, q);
		wb(1'b0, `MTCP_OFS_PAUSE_OPD, 32'h0);
		chk(32'h00011234, q);
		chk(48'h02A1B2C3D4E5, sta);
	endtask
	task automatic t_pause();
		logic [143:0] ex;
		ex = {48'h0180C2000001, 48'h02A1B2C3D4E5, 48'h880800011234};
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h4);
		wb(1'b1, `MTCP_OFS_MAC_CTRL, 32'h3);
		f0 = phy.n_frames;
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'hC);
		poll(`MTCP_OFS_TX_CTRL, 3, 1'b0);
		wait_frames(f0 + 1);
		for (int i = 0; i < 60; i++)
			chk(i < 18 ? ex[143 - 8 * i -: 8] : 8'h00, phy.rx_byte[i]);
		for (int i = 0; i < 4; i++)
			chk(8'(fcs_of(60) >> (8 * i)), phy.rx_byte[60 + i]);
		wb(1'b0, `MTCP_OFS_EVENT, 32'h0);
		chk(1'b1, q[0]);
		wb(1'b1, `MTCP_OFS_EVENT, 32'h1);
	endtask
	task automatic t_gstop();
		int i;
		col_req <= 1'b1;
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h5);
		wb(1'b0, `MTCP_OFS_EVENT, 32'h0);
		chk(1'b1, q[0]);
		wb(1'b1, `MTCP_OFS_EVENT, 32'h1);
		go();
		f0 = phy.n_frames;
		repeat (400) @(posedge clk);
		chk(f0, phy.n_frames);
		chk(1'b0, mii.tx_en);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h4);
		for (i = 0; i < 300 && mii.tx_en !== 1'b1; i++)
			@(posedge clk);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h5);
		poll(`MTCP_OFS_EVENT, 0, 1'b1);
		wait_frames(f0 + 1);
		for (i = 0; i < 64; i++)
			chk(i, phy.rx_byte[i]);
		wb(1'b1, `MTCP_OFS_EVENT, 32'h1);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h4);
		col_req <= 1'b0;
	endtask
	task automatic t_rxpause();
		rxp <= 1'b1;
		quanta <= 16'h0002;
		@(posedge clk);
		rxp <= 1'b0;
		go();
		f0 = phy.n_frames;
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'hC);
		poll(`MTCP_OFS_TX_CTRL, 3, 1'b0);
		chk(1'b1, q[4]);
		wait_frames(f0 + 1);
		chk(8'h01, phy.rx_byte[0]);
		poll(`MTCP_OFS_TX_CTRL, 4, 1'b0);
		wait_frames(f0 + 2);
		chk(8'h3F, phy.rx_byte[63]);
	endtask
	task automatic t_hbeat();
		wb(1'b1, `MTCP_OFS_MAC_CTRL, 32'h2);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h2);
		wb(1'b1, `MTCP_OFS_MAC_CTRL, 32'h3);
		go();
		wait_frames(phy.n_frames + 1);
		repeat (250) @(posedge clk);
		wb(1'b0, `MTCP_OFS_EVENT, 32'h0);
		chk(1'b1, q[1]);
		wb(1'b1, `MTCP_OFS_EVENT, 32'h2);
		go();
		wait_frames(phy.n_frames + 1);
		col_req <= 1'b1;
		repeat (20) @(posedge clk);
		col_req <= 1'b0;
		repeat (250) @(posedge clk);
		wb(1'b0, `MTCP_OFS_EVENT, 32'h0);
		chk(1'b0, q[1]);
	endtask
	// half duplex: collision in the preamble while stop is set
	task automatic t_col();
		int i;
		wb(1'b1, `MTCP_OFS_EVENT, 32'h1);
		go();
		f0 = phy.n_frames;
		for (i = 0; i < 300 && mii.tx_en !== 1'b1; i++)
			@(posedge clk);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h3);
		col_req <= 1'b1;
		repeat (40) @(posedge clk);
		col_req <= 1'b0;
		repeat (400) @(posedge clk);
		chk(1'b1, rew_seen);
		chk(f0 + 1, phy.n_frames);
		chk(1'b0, mii.tx_en);
		poll(`MTCP_OFS_EVENT, 0, 1'b1);
		wb(1'b1, `MTCP_OFS_MAC_CTRL, 32'h2);
		wb(1'b1, `MTCP_OFS_TX_CTRL, 32'h2);
		wb(1'b1, `MTCP_OFS_MAC_CTRL, 32'h3);
		wait_frames(f0 + 2);
		for (i = 0; i < 64; i++)
			chk(i, phy.rx_byte[i]);
	endtask

	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, col_req, f_valid, rxp, rew_seen} = 7'h00;
		adr = 8'h00;
		idx = 8'h00;
		sel = 4'hF;
		dat_w = 32'h0;
		quanta = 16'h0000;
		failures = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_addr();
		t_pause();
		t_gstop();
		t_rxpause();
		t_hbeat();
		t_col();
		test_done();
	end
endmodule // tb

bind mtcp_tx_ctrl mtcp_tx_ctrl_monitor mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
	.o_mii_tx(o_mii_tx), .o_station_addr(o_station_addr));
